// ---- core/seca_top.sv ----
// Serial EEPROM client front end: link engine, page buffer, program timer.
`timescale 1ns/10ps
module seca_top import seca_pkg::*; #(
   parameter int PROG_CYCLES = PROG_CYCLES_DFLT
) (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic scl_clk_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic wp_i,
   input wire logic strap_select_bit0_i,
   input wire logic strap_select_bit1_i,
   input wire logic strap_select_bit2_i,
   input wire logic [OFS_W-1:0] arr_rd_idx_i,
   output logic [BYTE_W-1:0] arr_rd_data_o,
   output logic arr_rd_valid_o,
   output logic [PAGE_W-1:0] prog_page_o,
   output logic prog_start_o,
   output logic busy_o,
   output logic standby_o
);

   localparam int TMR_W = $clog2(PROG_CYCLES + 1);
   localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(PROG_CYCLES - 1);

   // ========================================
   // Pin synchronisers, system side
   logic [2:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic wp_s;

   seca_sync #(
      .WIDTH(3)
   ) u_sys_sync (
      .clk_i(sys_clk_i),
      .rst_n_i(arst_n_i),
      .d_i({scl_clk_i, sda_i, wp_i}),
      .q_o(pins_s)
   );

   assign scl_s = pins_s[2];
   assign sda_s = pins_s[1];
   assign wp_s = pins_s[0];

   // ========================================
   // Start and Stop detection
   logic scl_q;
   logic sda_q;
   logic start_q;
   logic next_scl_q;
   logic next_sda_q;
   logic next_start_q;
   logic start_det;
   logic stop_det;

   always_comb begin
      start_det = scl_s & scl_q & sda_q & ~sda_s;
      stop_det = scl_s & scl_q & ~sda_q & sda_s;
      next_scl_q = scl_s;
      next_sda_q = sda_s;
      next_start_q = start_det;
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         start_q <= 1'b0;
      end else begin
         scl_q <= next_scl_q;
         sda_q <= next_sda_q;
         start_q <= next_start_q;
      end
   end

   // ========================================
   // Link run control
   // The link logic sits in reset outside frames and while programming.
   // A Start drops it for one cycle; SCL is held high through the
   // Start hold time, so the release lands long before the next edge.
   logic link_run;
   logic next_link_run;
   logic busy;
   logic link_rst_n;

   always_comb begin
      next_link_run = link_run;
      if (start_det) begin
         next_link_run = 1'b0;
      end else if (start_q && !busy) begin
         next_link_run = 1'b1;
      end else if (stop_det) begin
         next_link_run = 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         link_run <= 1'b0;
      end else begin
         link_run <= next_link_run;
      end
   end

   assign link_rst_n = arst_n_i & link_run;

   // ========================================
   // Link domain: strap pins
   logic [STRAP_W-1:0] strap_l;

   seca_sync #(
      .WIDTH(STRAP_W)
   ) u_link_sync (
      .clk_i(scl_clk_i),
      .rst_n_i(link_rst_n),
      .d_i({strap_select_bit2_i, strap_select_bit1_i,
            strap_select_bit0_i}),
      .q_o(strap_l)
   );

   // ========================================
   // Link domain: byte engine on rising SCL
   seca_link_state_t lstate;
   seca_link_state_t next_lstate;
   logic [BCNT_W-1:0] bcnt;
   logic [BCNT_W-1:0] next_bcnt;
   logic [BYTE_W-2:0] shreg;
   logic [BYTE_W-2:0] next_shreg;
   logic [ADDR_W-1:0] waddr;
   logic [ADDR_W-1:0] next_waddr;
   logic ack;
   logic next_ack;
   seca_wr_evt_t wr_evt;
   seca_wr_evt_t next_wr_evt;
   logic wr_tgl;
   logic next_wr_tgl;
   logic [BYTE_W-1:0] rx_byte;
   logic dev_match;

   always_comb begin
      rx_byte = {shreg, sda_i};
      dev_match = (rx_byte[TYPE_MSB:TYPE_LSB] == DEV_TYPE_ID) &&
                  (rx_byte[STRAP_MSB:STRAP_LSB] == strap_l);
      next_lstate = lstate;
      next_bcnt = bcnt;
      next_shreg = shreg;
      next_waddr = waddr;
      next_ack = ack;
      next_wr_evt = wr_evt;
      next_wr_tgl = wr_tgl;
      if (bcnt == ACK_SLOT) begin
         next_bcnt = '0;
      end else begin
         next_bcnt = bcnt + 1'b1;
         next_shreg = rx_byte[BYTE_W-2:0];
         if (bcnt == LAST_BIT) begin
            next_ack = 1'b0;
            case (lstate)
               LS_DEV: begin
                  next_ack = dev_match;
                  if (!dev_match) begin
                     next_lstate = LS_SKIP;
                  end else if (rx_byte[RW_BIT]) begin
                     // Reads are not served by this front end
                     next_lstate = LS_SKIP;
                  end else begin
                     next_lstate = LS_HI;
                  end
               end
               LS_HI: begin
                  next_waddr[ADDR_W-1:BYTE_W] = rx_byte;
                  next_ack = 1'b1;
                  next_lstate = LS_LO;
               end
               LS_LO: begin
                  next_waddr[BYTE_W-1:0] = rx_byte;
                  next_ack = 1'b1;
                  next_lstate = LS_DATA;
               end
               LS_DATA: begin
                  next_wr_evt.page = waddr[ADDR_W-1:OFS_W];
                  next_wr_evt.ofs = waddr[OFS_W-1:0];
                  next_wr_evt.data = rx_byte;
                  next_wr_tgl = ~wr_tgl;
                  // Page bits stay fixed; offset wraps in page
                  next_waddr[OFS_W-1:0] = waddr[OFS_W-1:0] + 1'b1;
                  next_ack = 1'b1;
               end
               LS_SKIP: begin
                  next_ack = 1'b0;
               end
               default: begin
                  next_lstate = LS_SKIP;
               end
            endcase
         end
      end
   end

   always_ff @(posedge scl_clk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         lstate <= LS_DEV;
         bcnt <= '0;
         shreg <= '0;
         waddr <= '0;
         ack <= 1'b0;
      end else begin
         lstate <= next_lstate;
         bcnt <= next_bcnt;
         shreg <= next_shreg;
         waddr <= next_waddr;
         ack <= next_ack;
      end
   end

   // Event word and toggle survive link resets so a byte taken
   // just before Stop still reaches the system side.
   always_ff @(posedge scl_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_evt <= '0;
         wr_tgl <= 1'b0;
      end else begin
         wr_evt <= next_wr_evt;
         wr_tgl <= next_wr_tgl;
      end
   end

   // ========================================
   // Link domain: acknowledge drive on falling SCL
   logic sda_drive;
   logic next_sda_drive;

   always_comb begin
      // Low through the ninth clock only, released after it
      next_sda_drive = (bcnt == ACK_SLOT) & ack;
   end

   always_ff @(negedge scl_clk_i or negedge link_rst_n) begin
      if (!link_rst_n) begin
         sda_drive <= 1'b0;
      end else begin
         sda_drive <= next_sda_drive;
      end
   end

   assign sda_o = 1'b0;
   assign sda_oe_o = sda_drive;

   // ========================================
   // Byte event crossing into system domain
   // Event word is stable for nine SCL periods after each toggle.
   logic tgl_s;
   logic tgl_q;
   logic next_tgl_q;
   logic byte_evt;

   seca_sync #(
      .WIDTH(1)
   ) u_tgl_sync (
      .clk_i(sys_clk_i),
      .rst_n_i(arst_n_i),
      .d_i(wr_tgl),
      .q_o(tgl_s)
   );

   always_comb begin
      next_tgl_q = tgl_s;
      byte_evt = tgl_s ^ tgl_q;
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tgl_q <= 1'b0;
      end else begin
         tgl_q <= next_tgl_q;
      end
   end

   // ========================================
   // Page buffer and program timer
   logic [BYTE_W-1:0] pbuf [PAGE_BYTES];
   logic [BYTE_W-1:0] next_pbuf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] mask;
   logic [PAGE_BYTES-1:0] next_mask;
   logic [PAGE_W-1:0] page;
   logic [PAGE_W-1:0] next_page;
   logic pend;
   logic next_pend;
   logic next_busy;
   logic [TMR_W-1:0] tmr;
   logic [TMR_W-1:0] next_tmr;
   logic next_prog_start;
   logic next_standby;

   always_comb begin
      next_pbuf = pbuf;
      next_mask = mask;
      next_page = page;
      next_pend = pend;
      next_busy = busy;
      next_tmr = tmr;
      next_prog_start = 1'b0;
      if (byte_evt) begin
         next_pbuf[wr_evt.ofs] = wr_evt.data;
         next_mask[wr_evt.ofs] = 1'b1;
         next_page = wr_evt.page;
         next_pend = 1'b1;
      end
      if (busy) begin
         if (tmr == '0) begin
            next_busy = 1'b0;
            next_mask = '0;
         end else begin
            next_tmr = tmr - 1'b1;
         end
      end else if (stop_det && link_run && pend) begin
         next_pend = 1'b0;
         if (wp_s) begin
            next_mask = '0;
         end else begin
            next_busy = 1'b1;
            next_tmr = TMR_LOAD;
            next_prog_start = 1'b1;
         end
      end
      next_standby = ~next_link_run & ~next_busy;
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pbuf <= '{default: '0};
         mask <= '0;
         page <= '0;
         pend <= 1'b0;
         busy <= 1'b0;
         tmr <= '0;
         prog_start_o <= 1'b0;
         standby_o <= 1'b1;
      end else begin
         pbuf <= next_pbuf;
         mask <= next_mask;
         page <= next_page;
         pend <= next_pend;
         busy <= next_busy;
         tmr <= next_tmr;
         prog_start_o <= next_prog_start;
         standby_o <= next_standby;
      end
   end

   // ========================================
   // Array-side read port
   logic [BYTE_W-1:0] next_rd_data;
   logic next_rd_valid;

   always_comb begin
      next_rd_data = pbuf[arr_rd_idx_i];
      next_rd_valid = mask[arr_rd_idx_i];
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         arr_rd_data_o <= '0;
         arr_rd_valid_o <= 1'b0;
      end else begin
         arr_rd_data_o <= next_rd_data;
         arr_rd_valid_o <= next_rd_valid;
      end
   end

   assign prog_page_o = page;
   assign busy_o = busy;

endmodule : seca_top

// ---- core/seca_pkg.sv ----
// Constants and types for the serial EEPROM client access block.
// Summary of operation
// - Standby after reset, plain Stop, program end
// - Release data line within nine dummy clocks
// - Array is 512 pages of 128 bytes
// - Respond only when upper four bits match type
// - Bits 3..1 must equal the strap pins
// - Bit 0 high reads, low writes
// - Acknowledge matching address byte, else refuse
// - First location byte is A15..A8
// - Second location byte is A7..A0
// - Acknowledge data byte; Stop starts programming
// - Ignore bus while programming runs
// - Up to 128 bytes, same page, per cycle
// - Acknowledge each further byte; program at Stop
// - Only low seven address bits advance
// - Refuse address while busy, acknowledge after
// - Protect pin high blocks all programming
// - Protect pin sampled at the starting Stop
// - Protected: acknowledge all, skip program, ready
// - Sample on rising clock, drive after falling
// - MSB first, ninth clock carries acknowledge
// - Data fall/rise while clock high: Start/Stop
// - Transmitter releases line after eighth bit
package seca_pkg;

   // ========================================
   // Geometry
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 16;
   localparam int OFS_W = 7;
   localparam int PAGE_W = ADDR_W - OFS_W;
   localparam int PAGE_BYTES = 128;
   localparam int NUM_PAGES = 512;
   localparam int STRAP_W = 3;

   // ========================================
   // Address byte fields
   localparam int TYPE_MSB = 7;
   localparam int TYPE_LSB = 4;
   localparam int STRAP_MSB = 3;
   localparam int STRAP_LSB = 1;
   localparam int RW_BIT = 0;
   // Arbitrary value, not a real device type
   localparam logic [3:0] DEV_TYPE_ID = 4'h5;

   // ========================================
   // Bit counter
   localparam int BCNT_W = 4;
   localparam logic [BCNT_W-1:0] LAST_BIT = 4'h7;
   localparam logic [BCNT_W-1:0] ACK_SLOT = 4'h8;

   // ========================================
   // Timing
   localparam int CLK_PERIOD_NS = 4;
   localparam int PROG_TIME_NS = 5000000;
   localparam int PROG_CYCLES_DFLT = PROG_TIME_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      LS_DEV,
      LS_HI,
      LS_LO,
      LS_DATA,
      LS_SKIP
   } seca_link_state_t;

   typedef struct packed {
      logic [PAGE_W-1:0] page;
      logic [OFS_W-1:0] ofs;
      logic [BYTE_W-1:0] data;
   } seca_wr_evt_t;

endpackage : seca_pkg

// ---- core/seca_sync.sv ----
// Two-flop level synchroniser for a group of bits.
`timescale 1ns/10ps
module seca_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);

   logic [WIDTH-1:0] meta;
   logic [WIDTH-1:0] next_meta;
   logic [WIDTH-1:0] next_q;

   always_comb begin
      next_meta = d_i;
      next_q = meta;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta <= '0;
         q_o <= '0;
      end else begin
         meta <= next_meta;
         q_o <= next_q;
      end
   end

endmodule : seca_sync

// ---- tb/seca_properties.sv ----
// Port checker for the serial EEPROM client front end.
`timescale 1ns/10ps
module seca_properties import seca_pkg::*; #(
   parameter int PROG_CYCLES = PROG_CYCLES_DFLT
) (
   input wire logic sys_clk_i,
   input wire logic arst_n_i,
   input wire logic scl_clk_i,
   input wire logic sda_oe_o,
   input wire logic wp_i,
   input wire logic prog_start_o,
   input wire logic busy_o,
   input wire logic standby_o
);
   int busy_cnt;
   int next_busy_cnt;
   always_comb next_busy_cnt = busy_o ? busy_cnt + 1 : 0;
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) busy_cnt <= 0;
      else busy_cnt <= next_busy_cnt;
   end
   // ========================================
   // Assertions
   start_busy_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      prog_start_o |=> busy_o) else $error("no busy after start pulse");
   pulse_once_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      prog_start_o |=> !prog_start_o) else $error("start pulse too long");
   busy_len_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      $fell(busy_o) |-> busy_cnt == PROG_CYCLES)
      else $error("program cycle has wrong length");
   standby_off_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      busy_o |-> !standby_o) else $error("standby while busy");
   busy_mute_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      busy_o |-> !sda_oe_o) else $error("data driven while busy");
   wp_block_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      wp_i [*8] |-> !prog_start_o) else $error("program while protected");
   ack_len_a:
   assert property (@(negedge scl_clk_i) disable iff (!arst_n_i)
      sda_oe_o |=> !sda_oe_o) else $error("acknowledge held too long");
   oe_edge_a:
   assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
      $changed(sda_oe_o) |-> !scl_clk_i) else $error("data moved, clock high");
   cover property (@(posedge sys_clk_i) prog_start_o);
   cover property (@(posedge sys_clk_i) $fell(busy_o));
   cover property (@(negedge scl_clk_i) sda_oe_o);
endmodule : seca_properties

bind seca_top seca_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (
   .sys_clk_i, .arst_n_i, .scl_clk_i, .sda_oe_o, .wp_i, .prog_start_o,
   .busy_o, .standby_o);

// ---- tb/seca_host.sv ----
// Bus host model driving the serial clock and data line.
`timescale 1ns/10ps
module seca_host (
   output logic scl_o,
   output logic sda_low_o,
   input wire logic sda_i
);
   initial begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
   end
   // Long clock-high phase so the synchronised detector sees it
   task start_cond();
      // Data moves after the clock falls, never with it
      #2 sda_low_o = 1'b0;
      #3 scl_o = 1'b1;
      #24 sda_low_o = 1'b1;
      #24 scl_o = 1'b0;
   endtask : start_cond
   // Returns at the Stop edge so the caller sees the reaction
   task stop_cond();
      #2 sda_low_o = 1'b1;
      #3 scl_o = 1'b1;
      #24 sda_low_o = 1'b0;
   endtask : stop_cond
   task put_bits(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         #2 sda_low_o = ~b[i];
         #4 scl_o = 1'b1;
         #6 scl_o = 1'b0;
      end
   endtask : put_bits
   task put_byte(input logic [7:0] b, output logic ack);
      put_bits(b);
      #2 sda_low_o = 1'b0;
      #4 scl_o = 1'b1;
      #3 ack = ~sda_i;
      #3 scl_o = 1'b0;
   endtask : put_byte
   task recover(output int n);
      n = 0;
      #2 sda_low_o = 1'b0;
      while (sda_i !== 1'b1 && n < 12) begin
         #6 scl_o = 1'b1;
         #6 scl_o = 1'b0;
         #2 n++;
      end
   endtask : recover
endmodule : seca_host

// ---- tb/tb_seca_top.sv ----
// Self-checking bench for the serial EEPROM client front end.
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
   $display("mismatch at %0t: got %0h exp %0h", $time, (a), (e)); end end
module tb_seca_top import seca_pkg::*; ;
   localparam int PCYC = 200;
   localparam logic [7:0] DEVW = {DEV_TYPE_ID, 3'h5, 1'b0};
   logic sys_clk = 1'b0, arst_n = 1'b0, wp = 1'b0, seen;
   logic [2:0] strap = 3'h5;
   logic [6:0] idx = 7'h00;
   logic [7:0] rd_data;
   logic [8:0] page;
   logic scl, host_low, oe, dout, rd_valid, pstart, busy, standby;
   wire sda = ~host_low & (~oe | dout);
   int fails = 0, num_checks = 0, cyc = 0, n;
   always #2 sys_clk = ~sys_clk;
   seca_host host (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda));
   seca_top #(.PROG_CYCLES(PCYC)) dut (.sys_clk_i(sys_clk),
      .arst_n_i(arst_n), .scl_clk_i(scl), .sda_i(sda), .sda_o(dout),
      .sda_oe_o(oe), .wp_i(wp), .strap_select_bit0_i(strap[0]),
      .strap_select_bit1_i(strap[1]), .strap_select_bit2_i(strap[2]),
      .arr_rd_idx_i(idx), .arr_rd_data_o(rd_data),
      .arr_rd_valid_o(rd_valid), .prog_page_o(page),
      .prog_start_o(pstart), .busy_o(busy), .standby_o(standby));
   // ========================================
   // Shared tasks
   task stop_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test
   task wr(input logic [7:0] b, input logic exp);
      logic ack;
      host.put_byte(b, ack);
      `CHK(ack, exp)
   endtask : wr
   task frame(input logic [7:0] hi, input logic [7:0] lo);
      host.start_cond();
      wr(DEVW, 1'b1);
      wr(hi, 1'b1);
      wr(lo, 1'b1);
   endtask : frame
   task wait_prog();
      seen = 1'b0;
      repeat (20) begin
         @(posedge sys_clk);
         if (pstart === 1'b1) seen = 1'b1;
      end
      #1;
   endtask : wait_prog
   task wait_idle();
      for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge sys_clk);
      @(posedge sys_clk);
      #1;
   endtask : wait_idle
   task rd(input logic [6:0] i, input logic [7:0] d, input logic v);
      @(posedge sys_clk) idx <= i;
      repeat (2) @(posedge sys_clk);
      #1 `CHK(rd_valid, v)
      if (v) `CHK(rd_data, d)
   endtask : rd
   // ========================================
   // Scenarios
   task t_byte();
      frame(8'h3C, 8'hD5);
      wr(8'hA7, 1'b1);
      host.stop_cond();
      wait_prog();
      `CHK(seen, 1'b1)
      `CHK(page, 9'h079)
      rd(7'h55, 8'hA7, 1'b1);
      host.start_cond();
      wr(DEVW, 1'b0);
      host.stop_cond();
      wait_idle();
      `CHK(standby, 1'b1)
      rd(7'h55, 8'h00, 1'b0);
      host.start_cond();
      wr(DEVW, 1'b1);
      host.stop_cond();
      wait_prog();
      `CHK(seen, 1'b0)
      $display("test byte write done");
   endtask : t_byte
   task t_addr();
      for (int k = 0; k < 8; k++) begin
         host.start_cond();
         wr({DEV_TYPE_ID, k[2:0], 1'b0}, k == 5);
         host.stop_cond();
      end
      @(posedge sys_clk) strap <= 3'h2;
      host.start_cond();
      wr({DEV_TYPE_ID, 3'h2, 1'b0}, 1'b1);
      host.stop_cond();
      @(posedge sys_clk) strap <= 3'h5;
      host.start_cond();
      wr({DEV_TYPE_ID ^ 4'h1, 3'h5, 1'b0}, 1'b0);
      host.stop_cond();
      host.start_cond();
      wr({DEV_TYPE_ID, 3'h5, 1'b1}, 1'b1);
      host.stop_cond();
      wait_prog();
      `CHK(seen, 1'b0)
      `CHK(standby, 1'b1)
      $display("test address decode done");
   endtask : t_addr
   task t_wrap();
      logic [7:0] dv [4];
      dv = '{8'h11, 8'h22, 8'h33, 8'h44};
      frame(8'hD2, 8'hFE);
      for (int i = 0; i < 4; i++) wr(dv[i], 1'b1);
      host.stop_cond();
      wait_prog();
      `CHK(seen, 1'b1)
      `CHK(page, 9'h1A5)
      rd(7'h7E, 8'h11, 1'b1);
      rd(7'h7F, 8'h22, 1'b1);
      rd(7'h00, 8'h33, 1'b1);
      rd(7'h01, 8'h44, 1'b1);
      rd(7'h02, 8'h00, 1'b0);
      wait_idle();
      $display("test page wrap done");
   endtask : t_wrap
   task t_wp();
      @(posedge sys_clk) wp <= 1'b1;
      frame(8'h01, 8'h02);
      wr(8'h5A, 1'b1);
      host.stop_cond();
      wait_prog();
      `CHK(seen, 1'b0)
      `CHK(busy, 1'b0)
      @(posedge sys_clk) wp <= 1'b0;
      frame(8'h01, 8'h02);
      wr(8'h5A, 1'b1);
      host.stop_cond();
      wait_prog();
      `CHK(seen, 1'b1)
      @(posedge sys_clk) wp <= 1'b1;
      repeat (4) @(posedge sys_clk);
      #1 `CHK(busy, 1'b1)
      wait_idle();
      `CHK(busy, 1'b0)
      `CHK(standby, 1'b1)
      @(posedge sys_clk) wp <= 1'b0;
      $display("test write protect done");
   endtask : t_wp
   task t_recover();
      host.start_cond();
      host.put_bits(DEVW);
      host.recover(n);
      `CHK(n > 0 && n <= 9, 1'b1)
      host.start_cond();
      wr(DEVW, 1'b1);
      host.stop_cond();
      $display("test bus recovery done");
   endtask : t_recover
   // ========================================
   // Run control
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         stop_test();
      end
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (5) @(posedge sys_clk);
      #1 `CHK(standby, 1'b1)
      t_byte();
      t_addr();
      t_wrap();
      t_wp();
      t_recover();
      stop_test();
   end
endmodule : tb_seca_top
